// ### hw/ssir_defines.svh
`ifndef SSIR_DEFINES_SVH
`define SSIR_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSIR_OFF_STATUS 8'h02
`define SSIR_OFF_CODE 8'h04
`define SSIR_OFF_STEP 8'h05
`define SSIR_OFF_CTRL 8'h10
`define SSIR_OFF_FLAGS 8'h11

// ----------------------------------------
// control and status bit positions
// ----------------------------------------
`define SSIR_CTRL_AUTO_SEL 0
`define SSIR_CTRL_AUTO_RESEL 1
`define SSIR_CTRL_MSGOUT_AFTER_SEL 2
`define SSIR_STAT_DATA_REQ 2
`define SSIR_STAT_INT_PEND 7

// ----------------------------------------
// interrupt codes
// ----------------------------------------
`define SSIR_IC_RESET_COND 8'h01
`define SSIR_IC_OFFSET_ERR 8'h29
`define SSIR_IC_REQACK_TMO 8'h2C
`define SSIR_IC_PHASE_ERR 8'h32
`define SSIR_IC_DISCONNECTED 8'h70
`define SSIR_IC_REQ_ASSERTED 8'h71
`define SSIR_IC_SELECTED 8'h80
`define SSIR_IC_SELECTED_ATN 8'h81
`define SSIR_IC_SEL_TIMEOUT 8'h82
`define SSIR_IC_RESELECTED 8'h90
`define SSIR_IC_AUTO_NO_ATN 8'hA0
`define SSIR_IC_AUTO_MSG 8'hA1
`define SSIR_IC_AUTO_BAD_IDENT 8'hA2
`define SSIR_IC_AUTO_IDENT_MSG 8'hA3
`define SSIR_IC_AUTO_UNK_CDB 8'hA4
`define SSIR_IC_AUTO_UNK_CDB_ID 8'hA5
`define SSIR_IC_AUTO_CDB 8'hA6
`define SSIR_IC_AUTO_CDB_ID 8'hA7
`define SSIR_IC_AUTO_CDB_MSG 8'hA8
`define SSIR_IC_AUTO_CDB_ID_MSG 8'hA9
`define SSIR_IC_AUTO_CDB_ATN 8'hAA
`define SSIR_IC_RESEL_PHASE_ERR 8'hB0
`define SSIR_IC_RESEL_MSG 8'hB1

// ----------------------------------------
// identify message illegal bits 5,4,3
// ----------------------------------------
`define SSIR_IDENT_BAD_MASK 8'h38
`define SSIR_STEP_IDLE 8'h00

`endif

// ### hw/ssir_pkg.sv
package ssir_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SSIR_EV_IDLE = 3'b001,
    SSIR_EV_ARMED = 3'b010,
    SSIR_EV_TERM = 3'b100
  } ssir_err_state_t;

  // step source selector
  typedef enum logic [1:0] {
    SSIR_CTX_READY = 2'd0,
    SSIR_CTX_DISCRETE = 2'd1,
    SSIR_CTX_PROGRAM = 2'd2,
    SSIR_CTX_AUTO = 2'd3
  } ssir_ctx_t;

endpackage : ssir_pkg

// ### hw/ssir_report.sv
`timescale 1ns/1ns
`include "ssir_defines.svh"

// ----------------------------------------
// selection / error interrupt reporting
// ----------------------------------------
// Functional notes
// RQ1: selection or reselection timeout raises code 82.
// RQ2: reselected as initiator raises 90 only when auto reselection response is off.
// RQ3: selected as target with auto response off raises 80, or 81 with ATN.
// RQ4: auto reselection: other phase raises B0, one message received raises B1.
// RQ5: auto selection into message out without ATN raises A0.
// RQ6: auto selection: plain message raises A1, identify with bits 5..3 set raises A2.
// RQ7: valid identify then one more message raises A3.
// RQ8: unknown group 6/7 length keeps first byte, raises A4, or A5 after identify.
// RQ9: complete command block raises A6, or A7 after identify.
// RQ10: attention message after command raises A8/A9; late attention without selection ATN raises AA.
// RQ11: host decodes by reading code at 04 and step at 05.
// RQ12: discrete/sequential command step sits in step bits 3..0.
// RQ13: user program: completed count in bits 7..4, step in bits 3..0.
// RQ14: auto selection: sequence type in bits 7..4, step in bits 3..0.
// RQ15: ready-state interrupts report step zero.
// RQ16: handshake timeout stops transfer and raises REQ/ACK timeout in either role.
// RQ17: initiator offset error asserts ATN, continues, reports at end or message out.
// RQ18: initiator offset error then other phase reports offset and phase errors.
// RQ19: target offset error suspends, terminates, then reports offset error.
// RQ20: initiator data-in offset overrun with full register flags error, asserts ATN, continues.
// RQ21: host treats long data request silence as a stall.
// RQ22: host pauses, services requests, reads 67 and 29, toggles ACK till phase change.
// RQ23: code 29 marks more REQ/ACK edges than the programmed offset.
// RQ24: code and step are held together until the host reads them.
module ssir_report
  import ssir_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // role and context from sequencer
  input wire logic is_target,
  input wire logic [1:0] op_ctx,
  input wire logic [3:0] cmd_step,
  input wire logic [3:0] cmds_done,
  input wire logic [3:0] auto_seq_type,
  input wire logic data_req,
  // selection timeout and ready-state events, one-cycle pulses
  input wire logic ev_sel_timeout,
  input wire logic ev_reselected,
  input wire logic ev_selected,
  input wire logic ev_sel_atn,
  input wire logic ev_disconnected,
  input wire logic ev_reset_cond,
  input wire logic ev_req_asserted,
  // automatic response events, one-cycle pulses
  input wire logic ev_resel_phase,
  input wire logic ev_msg_rx,
  input wire logic [7:0] msg_byte,
  input wire logic ev_msgout_no_atn,
  input wire logic ev_cdb_rx,
  input wire logic ev_cdb_unknown,
  input wire logic ev_atn_msg,
  input wire logic ev_late_atn,
  // transfer error events, one-cycle pulses
  input wire logic ev_handshake_tmo,
  input wire logic ev_offset_err,
  input wire logic ev_xfer_done,
  input wire logic ev_phase_change,
  input wire logic new_phase_msgout,
  input wire logic ev_term_done,
  input wire logic data_reg_full,
  // outputs to transfer logic
  output logic xfer_stop,
  output logic atn_assert,
  output logic cdb_first_only,
  output logic int_pending
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] code_reg, code_next;
  logic [7:0] step_reg, step_next;
  logic pend_reg, pend_next;
  logic [2:0] ctrl_reg;
  logic ident_reg, ident_next;
  logic sel_atn_reg, sel_atn_next;
  logic phase_err_reg, phase_err_next;
  logic [7:0] rdata_reg;
  ssir_err_state_t err_reg, err_next;

  wire logic auto_sel = ctrl_reg[`SSIR_CTRL_AUTO_SEL];
  wire logic auto_resel = ctrl_reg[`SSIR_CTRL_AUTO_RESEL];
  wire logic msgout_cfg = ctrl_reg[`SSIR_CTRL_MSGOUT_AFTER_SEL];

  // ----------------------------------------
  // synchronise the pin-side data request level
  // ----------------------------------------
  logic dma_transfer_request_s1_reg, dma_transfer_request_s2_reg;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dma_transfer_request_s1_reg <= 1'b0;
      dma_transfer_request_s2_reg <= 1'b0;
    end
    else
    begin
      dma_transfer_request_s1_reg <= data_req;
      dma_transfer_request_s2_reg <= dma_transfer_request_s1_reg;
    end
  end

  // step value for the current context
  function automatic logic [7:0] ssir_step(input logic [1:0] ctx, input logic [3:0] st,
                                          input logic [3:0] cnt, input logic [3:0] typ);
    logic [7:0] r;
    r = `SSIR_STEP_IDLE;
    case (ctx)
      SSIR_CTX_DISCRETE: r = {4'h0, st}; // RQ12
      SSIR_CTX_PROGRAM: r = {cnt, st}; // RQ13
      SSIR_CTX_AUTO: r = {typ, st}; // RQ14
      default: r = `SSIR_STEP_IDLE;
    endcase
    return r;
  endfunction : ssir_step

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  wire logic ident_msg = msg_byte[7];
  wire logic ident_bad = ident_msg && ((msg_byte & `SSIR_IDENT_BAD_MASK) != 8'h00);
  wire logic [7:0] ctx_step = ssir_step(op_ctx, cmd_step, cmds_done, auto_seq_type);
  wire logic rd_code = reg_rd && (reg_addr == `SSIR_OFF_CODE);
  wire logic rd_step = reg_rd && (reg_addr == `SSIR_OFF_STEP);
  wire logic init_offset = ev_offset_err && !is_target;

  // ----------------------------------------
  // interrupt selection and error sequencing
  // ----------------------------------------
  logic ev_any;
  logic [7:0] ev_code;
  logic ev_ready;

  always_comb
  begin
    ev_any = 1'b0;
    ev_code = 8'h00;
    ev_ready = 1'b0;
    err_next = err_reg;
    ident_next = ident_reg;
    sel_atn_next = sel_atn_reg;
    phase_err_next = phase_err_reg;
    // selection timeout and ready-state events
    if (ev_reset_cond)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_RESET_COND;
      ev_ready = 1'b1;
    end
    else if (ev_sel_timeout)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_SEL_TIMEOUT; // RQ1
    end
    else if (ev_reselected && !auto_resel)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_RESELECTED; // RQ2
      ev_ready = 1'b1;
    end
    else if ((ev_selected || ev_sel_atn) && !auto_sel)
    begin
      ev_any = 1'b1;
      ev_code = ev_sel_atn ? `SSIR_IC_SELECTED_ATN : `SSIR_IC_SELECTED; // RQ3
      ev_ready = 1'b1;
    end
    else if (ev_disconnected || ev_req_asserted)
    begin
      ev_any = 1'b1;
      ev_code = ev_disconnected ? `SSIR_IC_DISCONNECTED : `SSIR_IC_REQ_ASSERTED;
      ev_ready = 1'b1;
    end
    // automatic reselection response
    else if (auto_resel && !is_target && ev_resel_phase)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_RESEL_PHASE_ERR; // RQ4
    end
    else if (auto_resel && !is_target && ev_msg_rx)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_RESEL_MSG; // RQ4
    end
    // automatic selection response
    else if (auto_sel && is_target)
    begin
      if (ev_selected || ev_sel_atn)
      begin
        sel_atn_next = ev_sel_atn;
        ident_next = 1'b0;
      end
      else if (ev_msgout_no_atn && msgout_cfg)
      begin
        ev_any = 1'b1;
        ev_code = `SSIR_IC_AUTO_NO_ATN; // RQ5
      end
      else if (ev_msg_rx && ident_reg)
      begin
        ev_any = 1'b1;
        ev_code = `SSIR_IC_AUTO_IDENT_MSG; // RQ7
      end
      else if (ev_msg_rx && ident_bad)
      begin
        ev_any = 1'b1;
        ev_code = `SSIR_IC_AUTO_BAD_IDENT; // RQ6
      end
      else if (ev_msg_rx && ident_msg)
        ident_next = 1'b1;
      else if (ev_msg_rx)
      begin
        ev_any = 1'b1;
        ev_code = `SSIR_IC_AUTO_MSG; // RQ6
      end
      else if (ev_cdb_unknown)
      begin
        ev_any = 1'b1;
        ev_code = ident_reg ? `SSIR_IC_AUTO_UNK_CDB_ID : `SSIR_IC_AUTO_UNK_CDB; // RQ8
      end
      else if (ev_cdb_rx && ev_late_atn && !sel_atn_reg)
      begin
        ev_any = 1'b1;
        ev_code = `SSIR_IC_AUTO_CDB_ATN; // RQ10
      end
      else if (ev_cdb_rx && ev_atn_msg)
      begin
        ev_any = 1'b1;
        ev_code = ident_reg ? `SSIR_IC_AUTO_CDB_ID_MSG : `SSIR_IC_AUTO_CDB_MSG; // RQ10
      end
      else if (ev_cdb_rx)
      begin
        ev_any = 1'b1;
        ev_code = ident_reg ? `SSIR_IC_AUTO_CDB_ID : `SSIR_IC_AUTO_CDB; // RQ9
      end
    end
    // transfer errors
    if (ev_handshake_tmo && !ev_any)
    begin
      ev_any = 1'b1;
      ev_code = `SSIR_IC_REQACK_TMO; // RQ16
      err_next = SSIR_EV_IDLE;
    end
    else
    begin
      unique case (err_reg)
        SSIR_EV_IDLE:
        begin
          // a pending phase error survives here until it is loaded
          if (ev_offset_err)
            err_next = is_target ? SSIR_EV_TERM : SSIR_EV_ARMED; // RQ17 RQ19 RQ20
        end
        SSIR_EV_ARMED:
        begin
          if (!ev_any && (ev_xfer_done || (ev_phase_change && new_phase_msgout)))
          begin
            ev_any = 1'b1;
            ev_code = `SSIR_IC_OFFSET_ERR; // RQ17 RQ23
            err_next = SSIR_EV_IDLE;
          end
          else if (!ev_any && ev_phase_change)
          begin
            ev_any = 1'b1;
            ev_code = `SSIR_IC_OFFSET_ERR; // RQ18
            phase_err_next = 1'b1;
            err_next = SSIR_EV_IDLE;
          end
        end
        SSIR_EV_TERM:
        begin
          if (!ev_any && ev_term_done)
          begin
            ev_any = 1'b1;
            ev_code = `SSIR_IC_OFFSET_ERR; // RQ19
            err_next = SSIR_EV_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // latch code and step; hold until host reads
  // ----------------------------------------
  wire logic acked = pend_reg && rd_step;
  wire logic can_load = !pend_reg || acked;

  always_comb
  begin
    code_next = code_reg;
    step_next = step_reg;
    pend_next = pend_reg && !acked; // RQ11
    if (ev_any && can_load)
    begin
      code_next = ev_code; // RQ24
      step_next = ev_ready ? `SSIR_STEP_IDLE : ctx_step; // RQ15
      pend_next = 1'b1;
    end
    else if (phase_err_reg && can_load && err_reg == SSIR_EV_IDLE)
    begin
      code_next = `SSIR_IC_PHASE_ERR; // RQ18
      step_next = ctx_step;
      pend_next = 1'b1;
    end
  end

  wire logic phase_taken = phase_err_reg && can_load && !ev_any && err_reg == SSIR_EV_IDLE;

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  wire logic [7:0] stat_val = {pend_reg, 4'h0, dma_transfer_request_s2_reg, 2'b00};
  wire logic [7:0] rd_mux =
    (reg_addr == `SSIR_OFF_STATUS) ? stat_val :
    rd_code ? code_reg :
    rd_step ? step_reg :
    (reg_addr == `SSIR_OFF_CTRL) ? {5'h00, ctrl_reg} :
    (reg_addr == `SSIR_OFF_FLAGS) ? {5'h00, err_reg} : 8'h00;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code_reg <= 8'h00;
      step_reg <= 8'h00;
      pend_reg <= 1'b0;
      ctrl_reg <= 3'b000;
      ident_reg <= 1'b0;
      sel_atn_reg <= 1'b0;
      phase_err_reg <= 1'b0;
      err_reg <= SSIR_EV_IDLE;
      rdata_reg <= 8'h00;
    end
    else
    begin
      code_reg <= code_next;
      step_reg <= step_next;
      pend_reg <= pend_next;
      ident_reg <= ident_next;
      sel_atn_reg <= sel_atn_next;
      phase_err_reg <= phase_taken ? 1'b0 : phase_err_next;
      err_reg <= err_next;
      if (reg_wr && reg_addr == `SSIR_OFF_CTRL)
        ctrl_reg <= reg_wdata[2:0];
      if (reg_rd)
        rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign int_pending = pend_reg;
  assign xfer_stop = ev_handshake_tmo || (ev_offset_err && is_target) ||
                     err_reg == SSIR_EV_TERM; // RQ16 RQ19
  assign atn_assert = init_offset || err_reg == SSIR_EV_ARMED; // RQ17 RQ20
  assign cdb_first_only = ev_cdb_unknown && auto_sel; // RQ8

endmodule : ssir_report

// ### test/ssir_far_end.sv
`timescale 1ns/1ns
// ----------------------------------------
// far bus party: event pulses
// ----------------------------------------
module ssir_far_end (
  // clock
  input wire logic core_clk,
  // requests from bench
  input wire logic [18:0] req,
  input wire logic [7:0] msg,
  input wire logic to_msgout,
  // pulses toward the block
  output logic [18:0] ev,
  output logic [7:0] msg_byte,
  output logic new_phase_msgout
);
  // quiet start
  initial
  begin
    ev = '0;
    msg_byte = 8'h00;
    new_phase_msgout = 1'b0;
  end
  // one pulse per request; qualifiers scramble when not valid
  always @(posedge core_clk)
  begin
    ev <= req;
    msg_byte <= req[8] ? msg : ~msg_byte;
    new_phase_msgout <= req[17] ? to_msgout : ~new_phase_msgout;
  end
endmodule : ssir_far_end

// ### test/ssir_report_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module ssir_report_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // context and events
  input wire logic is_target,
  input wire logic [1:0] op_ctx,
  input wire logic ev_sel_timeout,
  input wire logic ev_cdb_unknown,
  input wire logic ev_handshake_tmo,
  input wire logic ev_offset_err,
  input wire logic ev_xfer_done,
  input wire logic ev_phase_change,
  input wire logic ev_term_done,
  // outputs
  input wire logic xfer_stop,
  input wire logic atn_assert,
  input wire logic cdb_first_only,
  input wire logic int_pending
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // held pair, stable code reads and selection timeout raise
  a_pair_hold: assert property (
    int_pending && !(reg_rd && reg_addr == 8'h05) |=> int_pending)
    else $error("pair dropped early");
  a_code_stable: assert property (
    (int_pending && reg_rd && reg_addr == 8'h04) ##1
    (int_pending && reg_rd && reg_addr == 8'h04) |=> $stable(reg_rdata))
    else $error("code changed while held");
  a_seltmo_raise: assert property (
    ev_sel_timeout && !int_pending |=> int_pending)
    else $error("timeout not reported");
  // transfer error reactions and unknown command block cut
  a_tmo_stop: assert property (
    ev_handshake_tmo |-> xfer_stop)
    else $error("timeout did not stop");
  a_init_atn: assert property (
    ev_offset_err && !is_target && !ev_handshake_tmo |-> atn_assert)
    else $error("no attention on offset");
  a_atn_held: assert property (
    ev_offset_err && !is_target && !ev_handshake_tmo ##1
    !ev_xfer_done && !ev_phase_change && !ev_handshake_tmo |-> atn_assert)
    else $error("attention dropped");
  a_tgt_stop: assert property (
    ev_offset_err && is_target |-> xfer_stop)
    else $error("target kept going");
  a_tgt_hold: assert property (
    ev_offset_err && is_target ##1 !ev_term_done |-> xfer_stop)
    else $error("stop released early");
  a_cdb_first: assert property (
    ev_cdb_unknown && op_ctx == 2'h3 |-> cdb_first_only)
    else $error("unknown block not cut");
endmodule : ssir_report_chk

bind ssir_report ssir_report_chk u_chk (
  .core_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .is_target, .op_ctx, .ev_sel_timeout,
  .ev_cdb_unknown, .ev_handshake_tmo, .ev_offset_err, .ev_xfer_done, .ev_phase_change,
  .ev_term_done, .xfer_stop, .atn_assert, .cdb_first_only, .int_pending
);

// ### test/ssir_report_test.sv
`timescale 1ns/1ns
module ssir_report_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic is_target = 1'b0;
  logic data_req = 1'b0;
  logic data_reg_full = 1'b0;
  logic to_msgout = 1'b0;
  logic [1:0] op_ctx = 2'h0;
  logic [3:0] cmd_step = 4'h0;
  logic [3:0] cmds_done = 4'h0;
  logic [3:0] auto_seq_type = 4'h0;
  logic [18:0] req = '0;
  logic [18:0] ev;
  logic [7:0] msg = 8'h00;
  logic [7:0] msg_byte, reg_rdata, rd, es;
  logic new_phase_msgout, xfer_stop, atn_assert, cdb_first_only, int_pending;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // event table: masks, codes, role, message byte
  int tv [14] = '{1, 2, 4, 12, 16, 32, 64, 2048, 1024, 512, 256, 256, 128, 256};
  logic [7:0] tc [14] = '{8'h82, 8'h90, 8'h80, 8'h81, 8'h70, 8'h01, 8'h71,
                          8'hA4, 8'hA6, 8'hA0, 8'hA1, 8'hA2, 8'hB0, 8'hB1};
  logic [13:0] tt = 14'b00111110001100;
  logic [7:0] tm [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h01, 8'hB8, 8'h00, 8'h07};

  ssir_report DUT (
    .core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .is_target,
    .op_ctx, .cmd_step, .cmds_done, .auto_seq_type, .data_req, .ev_sel_timeout(ev[0]),
    .ev_reselected(ev[1]), .ev_selected(ev[2]), .ev_sel_atn(ev[3]),
    .ev_disconnected(ev[4]), .ev_reset_cond(ev[5]), .ev_req_asserted(ev[6]),
    .ev_resel_phase(ev[7]), .ev_msg_rx(ev[8]), .msg_byte, .ev_msgout_no_atn(ev[9]),
    .ev_cdb_rx(ev[10]), .ev_cdb_unknown(ev[11]), .ev_atn_msg(ev[12]), .ev_late_atn(ev[13]),
    .ev_handshake_tmo(ev[14]), .ev_offset_err(ev[15]), .ev_xfer_done(ev[16]),
    .ev_phase_change(ev[17]), .new_phase_msgout, .ev_term_done(ev[18]), .data_reg_full,
    .xfer_stop, .atn_assert, .cdb_first_only, .int_pending
  );
  ssir_far_end far (.core_clk, .req, .msg, .to_msgout, .ev, .msg_byte, .new_phase_msgout);

  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic fire(input logic [18:0] m);
    @(posedge core_clk);
    req <= m;
    @(posedge core_clk);
    req <= '0;
  endtask : fire

  // wait for a held pair, then status, code and step
  task automatic expect_int(input logic [7:0] c, input logic [7:0] s, input logic [7:0] k);
    for (int n = 0; n < 8 && int_pending !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    rd_reg(8'h02);
    cmp(rd & 8'h80, 8'h80);
    rd_reg(8'h04);
    cmp(rd, c);
    rd_reg(8'h05);
    cmp(rd & k, s & k);
  endtask : expect_int

  initial
  begin
    void'($urandom(32641));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      if (i == 7)
      begin
        wr_reg(8'h10, 8'h07);
        op_ctx <= 2'h3;
      end
      is_target <= tt[i];
      msg <= tm[i];
      auto_seq_type <= 4'($urandom);
      cmd_step <= 4'($urandom);
      fire(19'(tv[i]));
      es = (i < 7) ? 8'h00 : {auto_seq_type, cmd_step};
      expect_int(tc[i], es, 8'hFF);
    end
    // identify, command and attention chains under auto selection
    is_target <= 1'b1;
    fire(19'h0_0008);
    msg <= 8'h80;
    fire(19'h0_0100);
    msg <= 8'h07;
    fire(19'h0_0100);
    expect_int(8'hA3, {auto_seq_type, cmd_step}, 8'hFF);
    fire(19'h0_0800);
    // two back-to-back code reads while held
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= 8'h04;
    repeat (2) @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, 8'hA5);
    expect_int(8'hA5, {auto_seq_type, cmd_step}, 8'hFF);
    fire(19'h0_0400);
    expect_int(8'hA7, {auto_seq_type, cmd_step}, 8'hFF);
    fire(19'h0_1400);
    expect_int(8'hA9, {auto_seq_type, cmd_step}, 8'hFF);
    fire(19'h0_0004);
    fire(19'h0_2400);
    expect_int(8'hAA, {auto_seq_type, cmd_step}, 8'hFF);
    fire(19'h0_1400);
    expect_int(8'hA8, {auto_seq_type, cmd_step}, 8'hFF);
    is_target <= 1'b0;
    fire(19'h0_0002);
    rd_reg(8'h02);
    cmp(rd & 8'h80, 8'h00);
    wr_reg(8'h10, 8'h00);
    op_ctx <= 2'h1;
    fire(19'h0_4000);
    expect_int(8'h2C, {4'h0, cmd_step}, 8'h0F);
    op_ctx <= 2'h2;
    cmds_done <= 4'($urandom);
    data_reg_full <= 1'b1;
    fire(19'h0_8000);
    repeat (2) @(posedge core_clk);
    #1 cmp({6'h00, atn_assert, int_pending}, 8'h02);
    fire(19'h1_0000);
    expect_int(8'h29, {cmds_done, cmd_step}, 8'hFF);
    cmp({7'h00, atn_assert}, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      to_msgout <= m[0];
      fire(19'h0_8000);
      fire(19'h2_0000);
      expect_int(8'h29, {cmds_done, cmd_step}, 8'hFF);
      if (m == 0)
        expect_int(8'h32, {cmds_done, cmd_step}, 8'hFF);
    end
    repeat (3) @(posedge core_clk);
    #1 cmp({7'h00, int_pending}, 8'h00);
    is_target <= 1'b1;
    fire(19'h0_8000);
    repeat (2) @(posedge core_clk);
    #1 cmp({6'h00, xfer_stop, int_pending}, 8'h02);
    fire(19'h4_0000);
    expect_int(8'h29, {cmds_done, cmd_step}, 8'hFF);
    // second event while held is dropped
    op_ctx <= 2'h0;
    fire(19'h0_0001);
    fire(19'h0_0010);
    expect_int(8'h82, 8'h00, 8'hFF);
    data_req <= 1'b1;
    wr_reg(8'h10, 8'h05);
    rd_reg(8'h10);
    cmp(rd, 8'h05);
    rd_reg(8'h3C);
    cmp(rd, 8'h00);
    rd_reg(8'h02);
    cmp(rd & 8'h04, 8'h04);
    // reset in mid-run, asserted before the reset-condition pulse can latch, leaves no pair
    fire(19'h0_0020);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 cmp({7'h00, int_pending}, 8'h00);
    arst_n <= 1'b1;
    // first event after the second release
    fire(19'h0_0001);
    expect_int(8'h82, 8'h00, 8'hFF);
    wrap_up();
  end
endmodule : ssir_report_test
